/* File: rtl/fmc_adjust_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module fmc_adjust_timer
  import fmc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             monitorTick,
  input  wire logic [ADJ_W-1:0] intervalCode,
  output var  logic             adjDecrease,
  output var  logic             adjIncrease
);

  logic [CNT_W-1:0] decCount_r;
  logic [CNT_W-1:0] incCount_r;
  logic [CNT_W-1:0] decLimit;
  logic [CNT_W-1:0] incLimit;
  logic             decHit;
  logic             incHit;

  function automatic logic [CNT_W-1:0] scaled(input logic [CNT_W-1:0] base,
                                               input logic [ADJ_W-1:0] code);
    scaled = base << code;
  endfunction : scaled

  assign decLimit = scaled(DEC_BASE_CYCLES, intervalCode);
  assign incLimit = scaled(INC_BASE_CYCLES, intervalCode);
  // Compare with >= so that shortening the interval never strands the counter
  assign decHit   = monitorTick && (decCount_r + 12'h001 >= decLimit);
  assign incHit   = monitorTick && (incCount_r + 12'h001 >= incLimit);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      decCount_r  <= '0;
      incCount_r  <= '0;
      adjDecrease <= 1'b0;
      adjIncrease <= 1'b0;
    end else begin
      adjDecrease <= decHit;
      adjIncrease <= incHit;
      if (monitorTick) begin
        decCount_r <= decHit ? '0 : decCount_r + 12'h001;
        incCount_r <= incHit ? '0 : incCount_r + 12'h001;
      end
    end
  end

  a_dec_after_tick : assert property (@(posedge clk) disable iff (!nrst)
    adjDecrease |-> $past(monitorTick))
    else $error("decrease pulse without a monitoring tick");

endmodule : fmc_adjust_timer
`default_nettype wire

/* File: rtl/fmc_config_lock_bank.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fmc_config_lock_bank
  import fmc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [DATA_W-1:0] regRdata,
  input  wire logic              monitorTick,
  input  wire logic [DATA_W-1:0] pwmDemand1,
  input  wire logic [DATA_W-1:0] pwmDemand2,
  input  wire logic [DATA_W-1:0] pwmDemand3,
  output var  logic [DATA_W-1:0] pwmDuty1,
  output var  logic [DATA_W-1:0] pwmDuty2,
  output var  logic [DATA_W-1:0] pwmDuty3,
  output var  logic              monitorRun,
  output var  logic              lockActive,
  output var  logic              powerReady,
  output var  logic              forceFullFan,
  output var  logic              powerCalcFlag,
  output var  logic              spinupPulseSkip,
  output var  logic              busTimeoutSelect,
  output var  logic              supply5vSelect,
  output var  logic              adjDecrease,
  output var  logic              adjIncrease
);

  // Storage
  logic [DATA_W-1:0]  ceil_r [CHANNELS];
  logic [DATA_W-1:0]  duty_r [CHANNELS];
  logic [DATA_W-1:0]  dutyNxt [CHANNELS];
  logic [DATA_W-1:0]  demand [CHANNELS];
  logic [DATA_W-1:0]  effCeil [CHANNELS];
  logic [ADJ_W-1:0]   adjInterval_r;
  logic               run_r;
  logic               lock_r;
  logic               ready_r;
  logic               fullFan_r;
  logic               powerCalc_r;
  logic               spinSkip_r;
  logic               busTimeout_r;
  logic               supply5v_r;
  logic [PWRUP_W-1:0] pwrupCount_r;
  logic [DATA_W-1:0]  rdata_r;

  // Decode
  logic               hitCeil [CHANNELS];
  logic               hitSetup;
  logic               hitAdj;
  logic               wrCeil [CHANNELS];
  logic               wrSetup;
  logic               wrSetupLockable;
  logic               wrAdj;
  logic [DATA_W-1:0]  setupWord;
  logic [DATA_W-1:0]  rdataNxt;
  logic               pwrupDone;

  function automatic logic [DATA_W-1:0] minByte(input logic [DATA_W-1:0] a,
                                                input logic [DATA_W-1:0] b);
    minByte = (a < b) ? a : b;
  endfunction : minByte

  function automatic logic [ADDR_W-1:0] ceilOffset(input int idx);
    case (idx)
      0:       ceilOffset = OFS_CEIL_PWM1;
      1:       ceilOffset = OFS_CEIL_PWM2;
      default: ceilOffset = OFS_CEIL_PWM3;
    endcase
  endfunction : ceilOffset

  assign demand[0] = pwmDemand1;
  assign demand[1] = pwmDemand2;
  assign demand[2] = pwmDemand3;

  assign hitSetup  = (regAddr == OFS_SETUP);
  assign hitAdj    = (regAddr == OFS_ADJ_INTERVAL);

  // A locked write still completes on the bus; only the store of the lockable fields is suppressed
  assign wrSetup         = regWr && hitSetup;
  assign wrSetupLockable = wrSetup && !lock_r;
  assign wrAdj           = regWr && hitAdj && !lock_r;

  // Run clear falls back to full-duty defaults; stored ceilings stay untouched
  for (genvar c = 0; c < CHANNELS; c++) begin : gChan
    assign hitCeil[c] = (regAddr == ceilOffset(c));
    assign wrCeil[c]  = regWr && hitCeil[c] && !lock_r;
    assign effCeil[c] = run_r ? ceil_r[c] : FULL_DUTY;
    // Full fan drives the ceiling itself, so the cap still holds
    assign dutyNxt[c] = fullFan_r ? effCeil[c]
                                  : minByte(demand[c], effCeil[c]);
  end

  assign setupWord = {supply5v_r, busTimeout_r, spinSkip_r, powerCalc_r,
                      fullFan_r, ready_r, lock_r, run_r};

  assign rdataNxt = !regRd            ? UNMAPPED_READ :
                    hitSetup          ? setupWord :
                    hitCeil[0]        ? ceil_r[0] :
                    hitCeil[1]        ? ceil_r[1] :
                    hitCeil[2]        ? ceil_r[2] :
                    hitAdj            ? {{(DATA_W-ADJ_W){1'b0}}, adjInterval_r} :
                                        UNMAPPED_READ;

  assign pwrupDone = (pwrupCount_r == PWRUP_W'(POWERUP_CYCLES));

  // Duty ceilings
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        ceil_r[c] <= RST_CEIL;
        duty_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (wrCeil[c]) begin
          ceil_r[c] <= regWdata;
        end
        duty_r[c] <= dutyNxt[c];
      end
    end
  end

  // Setup word; only the power-on reset can clear the lock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_r        <= RST_SETUP[BIT_RUN];
      lock_r       <= RST_SETUP[BIT_LOCK];
      fullFan_r    <= RST_SETUP[BIT_FULL_FAN];
      powerCalc_r  <= RST_SETUP[BIT_POWER_CALC];
      spinSkip_r   <= RST_SETUP[BIT_SPIN_SKIP];
      busTimeout_r <= RST_SETUP[BIT_BUS_TIMEOUT];
      supply5v_r   <= RST_SETUP[BIT_SUPPLY_5V];
    end else begin
      if (wrSetupLockable) begin
        run_r        <= regWdata[BIT_RUN];
        lock_r       <= regWdata[BIT_LOCK];
        powerCalc_r  <= regWdata[BIT_POWER_CALC];
        busTimeout_r <= regWdata[BIT_BUS_TIMEOUT];
        supply5v_r   <= regWdata[BIT_SUPPLY_5V];
      end
      if (wrSetup) begin
        fullFan_r  <= regWdata[BIT_FULL_FAN];
        spinSkip_r <= regWdata[BIT_SPIN_SKIP];
      end
    end
  end

  // Adjust interval, lockable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      adjInterval_r <= RST_ADJ_INTERVAL;
    end else if (wrAdj) begin
      adjInterval_r <= regWdata[ADJ_LSB +: ADJ_W];
    end
  end

  // Ready after the settling count; sticky until the next reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwrupCount_r <= '0;
      ready_r      <= 1'b0;
    end else begin
      if (!pwrupDone) begin
        pwrupCount_r <= pwrupCount_r + PWRUP_W'(1);
      end
      if (pwrupDone) begin
        ready_r <= 1'b1;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_r <= UNMAPPED_READ;
    end else begin
      rdata_r <= rdataNxt;
    end
  end

  fmc_adjust_timer uTimer (
    .clk          (clk),
    .nrst         (nrst),
    .monitorTick  (monitorTick && run_r),
    .intervalCode (adjInterval_r),
    .adjDecrease  (adjDecrease),
    .adjIncrease  (adjIncrease)
  );

  assign regRdata         = rdata_r;
  assign pwmDuty1         = duty_r[0];
  assign pwmDuty2         = duty_r[1];
  assign pwmDuty3         = duty_r[2];
  assign monitorRun       = run_r;
  assign lockActive       = lock_r;
  assign powerReady       = ready_r;
  assign forceFullFan     = fullFan_r;
  assign powerCalcFlag    = powerCalc_r;
  assign spinupPulseSkip  = spinSkip_r;
  assign busTimeoutSelect = busTimeout_r;
  assign supply5vSelect   = supply5v_r;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence sLockedCeilWrite;
    lock_r && regWr && regAddr == OFS_CEIL_PWM1;
  endsequence

  sequence sLockedSetupWrite;
    lock_r && regWr && regAddr == OFS_SETUP;
  endsequence

  sequence sOpenSetupWrite;
    !lock_r && regWr && regAddr == OFS_SETUP;
  endsequence

  sequence sLockWrite;
    !lock_r && regWr && regAddr == OFS_SETUP && regWdata[BIT_LOCK];
  endsequence

  a_lock_sticky : assert property (
    lock_r |=> lock_r)
    else $error("lock cleared without power cycle");

  a_ceiling_frozen : assert property (
    sLockedCeilWrite |=> $stable(ceil_r[0]))
    else $error("locked ceiling changed by a write");

  a_ceiling_stored : assert property (
    !lock_r && regWr && regAddr == OFS_CEIL_PWM2 |=> ceil_r[1] == $past(regWdata))
    else $error("ceiling write not stored");

  a_run_frozen : assert property (
    sLockedSetupWrite |=> $stable(run_r) && $stable(supply5v_r))
    else $error("locked setup bits changed");

  a_fullfan_open : assert property (
    sLockedSetupWrite |=> fullFan_r == $past(regWdata[BIT_FULL_FAN]))
    else $error("full fan bit refused a write under lock");

  a_duty_capped : assert property (
    run_r && !(regWr && regAddr == OFS_CEIL_PWM3) |=> pwmDuty3 <= ceil_r[2])
    else $error("duty above channel ceiling");

  a_run_off_default : assert property (
    !run_r && !fullFan_r |=> pwmDuty1 == $past(pwmDemand1))
    else $error("run clear did not use default ceiling");

  a_fullfan_duty : assert property (
    fullFan_r && !run_r |=> pwmDuty2 == FULL_DUTY)
    else $error("full fan not at full duty");

  a_setup_readback : assert property (
    regRd && regAddr == OFS_SETUP |=> regRdata == $past(setupWord)
    ##1 ($past(regRd) || regRdata == UNMAPPED_READ))
    else $error("setup word read data wrong");

  a_ready_held : assert property (
    powerReady |=> powerReady [*4])
    else $error("ready flag dropped");

  a_ready_timely : assert property (
    $rose(nrst) |-> ##[1:200] powerReady)
    else $error("ready flag late");

  a_ready_not_early : assert property (
    $rose(nrst) |-> !powerReady [*8])
    else $error("ready flag before settling");

  a_lock_taken : assert property (
    sLockWrite |=> lock_r)
    else $error("lock write not taken");

  a_lock_source : assert property (
    $rose(lock_r) |-> $past(regWr) && $past(regAddr) == OFS_SETUP && $past(regWdata[BIT_LOCK]))
    else $error("lock set without a lock write");

  a_adj_frozen : assert property (
    lock_r && regWr && regAddr == OFS_ADJ_INTERVAL |=> $stable(adjInterval_r))
    else $error("locked interval changed by a write");

  a_calc_frozen : assert property (
    sLockedSetupWrite |=> $stable(powerCalc_r))
    else $error("locked power flag changed");

  a_timeout_frozen : assert property (
    sLockedSetupWrite |=> $stable(busTimeout_r))
    else $error("locked bus timeout bit changed");

  a_spin_open : assert property (
    sLockedSetupWrite |=> spinSkip_r == $past(regWdata[BIT_SPIN_SKIP]))
    else $error("spin-up bit refused a write under lock");

  a_calc_stored : assert property (
    sOpenSetupWrite |=> powerCalc_r == $past(regWdata[BIT_POWER_CALC]))
    else $error("power flag write not stored");

  a_timeout_stored : assert property (
    sOpenSetupWrite |=> busTimeout_r == $past(regWdata[BIT_BUS_TIMEOUT]))
    else $error("bus timeout write not stored");

  a_supply_stored : assert property (
    sOpenSetupWrite |=> supply5v_r == $past(regWdata[BIT_SUPPLY_5V]))
    else $error("supply scaling write not stored");

  a_duty1_capped : assert property (
    run_r && !(regWr && regAddr == OFS_CEIL_PWM1) |=> pwmDuty1 <= ceil_r[0])
    else $error("duty above channel ceiling");

  a_duty2_capped : assert property (
    run_r && !(regWr && regAddr == OFS_CEIL_PWM2) |=> pwmDuty2 <= ceil_r[1])
    else $error("duty above channel ceiling");

  a_run_passthru : assert property (
    run_r && !fullFan_r && pwmDemand2 <= ceil_r[1] |=> pwmDuty2 == $past(pwmDemand2))
    else $error("demand under ceiling not passed through");

  a_run_clipped : assert property (
    run_r && !fullFan_r && pwmDemand3 > ceil_r[2] |=> pwmDuty3 == $past(ceil_r[2]))
    else $error("demand above ceiling not clipped");

  a_fullfan_ceiling : assert property (
    fullFan_r && run_r |=> pwmDuty1 == $past(ceil_r[0]))
    else $error("full fan not at programmed ceiling");

  a_timer_gated : assert property (
    !run_r |=> !adjDecrease && !adjIncrease)
    else $error("adjust pulse while monitoring stopped");

endmodule : fmc_config_lock_bank
`default_nettype wire

/* File: rtl/fmc_pkg.sv */
package fmc_pkg;

  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 8;
  localparam int          CHANNELS        = 3;

  // Register offsets
  localparam logic [7:0]  OFS_CEIL_PWM1   = 8'h38;
  localparam logic [7:0]  OFS_CEIL_PWM2   = 8'h39;
  localparam logic [7:0]  OFS_CEIL_PWM3   = 8'h3a;
  localparam logic [7:0]  OFS_ADJ_INTERVAL = 8'h3c;
  localparam logic [7:0]  OFS_SETUP       = 8'h40;

  // Values after reset, and the full-duty level
  localparam logic [7:0]  RST_CEIL        = 8'hff;
  localparam logic [7:0]  RST_SETUP       = 8'h01;
  localparam logic [2:0]  RST_ADJ_INTERVAL = 3'h0;
  localparam logic [7:0]  FULL_DUTY       = 8'hff;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  // Bit positions in the setup word
  localparam int          BIT_RUN         = 0;
  localparam int          BIT_LOCK        = 1;
  localparam int          BIT_READY       = 2;
  localparam int          BIT_FULL_FAN    = 3;
  localparam int          BIT_POWER_CALC  = 4;
  localparam int          BIT_SPIN_SKIP   = 5;
  localparam int          BIT_BUS_TIMEOUT = 6;
  localparam int          BIT_SUPPLY_5V   = 7;

  // Field of the adjust-interval register
  localparam int          ADJ_LSB         = 0;
  localparam int          ADJ_W           = 3;

  // Monitoring cycles for interval code 000; each code step doubles them
  localparam logic [11:0] DEC_BASE_CYCLES = 12'h008;
  localparam logic [11:0] INC_BASE_CYCLES = 12'h010;
  localparam int          CNT_W           = 12;

  // Settling time before the ready flag rises
  localparam int          POWERUP_NS      = 2000;
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          POWERUP_CYCLES  = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PWRUP_W         = 8;

endpackage : fmc_pkg

/* File: testbench/fmc_config_lock_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin nFail++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module fmc_config_lock_bank_bench
  import fmc_pkg::*;
;
  logic              clk;
  logic              nrst;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic              regWr;
  logic              regRd;
  logic [DATA_W-1:0] regRdata;
  logic              monitorTick;
  logic [DATA_W-1:0] pwmDemand1, pwmDemand2, pwmDemand3;
  logic [DATA_W-1:0] pwmDuty1, pwmDuty2, pwmDuty3;
  logic              monitorRun, lockActive, powerReady, forceFullFan;
  logic              powerCalcFlag, spinupPulseSkip, busTimeoutSelect, supply5vSelect;
  logic              adjDecrease, adjIncrease;
  logic [DATA_W-1:0] got;
  int                nFail, numChecks, nDec, nInc;

  fmc_config_lock_bank u_dut (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .monitorTick(monitorTick),
    .pwmDemand1(pwmDemand1), .pwmDemand2(pwmDemand2), .pwmDemand3(pwmDemand3),
    .pwmDuty1(pwmDuty1), .pwmDuty2(pwmDuty2), .pwmDuty3(pwmDuty3),
    .monitorRun(monitorRun), .lockActive(lockActive), .powerReady(powerReady),
    .forceFullFan(forceFullFan), .powerCalcFlag(powerCalcFlag),
    .spinupPulseSkip(spinupPulseSkip), .busTimeoutSelect(busTimeoutSelect),
    .supply5vSelect(supply5vSelect), .adjDecrease(adjDecrease), .adjIncrease(adjIncrease)
  );

  always #10 clk = ~clk;

  // Pulses are one cycle wide, so they are counted at every edge
  always @(posedge clk) begin
    if (adjDecrease !== 1'b0) nDec++;
    if (adjIncrease !== 1'b0) nInc++;
  end

  task automatic endSim();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : endSim

  task automatic doReset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    nDec = 0;
    nInc = 0;
  endtask : doReset

  // A free cycle is left before each strobe so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 got = regRdata;
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      monitorTick <= 1'b1;
      @(posedge clk);
      monitorTick <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask : ticks

  task automatic demand(input logic [7:0] d);
    @(posedge clk);
    pwmDemand1 <= d;
    pwmDemand2 <= d;
    pwmDemand3 <= d;
    repeat (3) @(posedge clk);
  endtask : demand

  initial begin
    repeat (60000) @(posedge clk);
    nFail++;
    endSim();
  end

  initial begin
    clk = 1'b0; nrst = 1'b0; regAddr = 8'h00; regWdata = 8'h00; regWr = 1'b0;
    regRd = 1'b0; monitorTick = 1'b0;
    pwmDemand1 = 8'h00; pwmDemand2 = 8'h00; pwmDemand3 = 8'h00;
    nFail = 0; numChecks = 0;
    doReset();
    `CHK(powerReady, 1'b0)
    for (int i = 0; i < CHANNELS; i++) begin
      rd(OFS_CEIL_PWM1 + 8'(i));
      `CHK(got, 8'hff)
    end
    rd(OFS_SETUP);
    `CHK(got, 8'h01)
    rd(8'h3b);
    `CHK(got, 8'h00)
    repeat (110) @(posedge clk);
    `CHK(powerReady, 1'b1)
    rd(OFS_SETUP);
    `CHK(got, 8'h05)
    wr(OFS_CEIL_PWM1, 8'h40);
    wr(OFS_CEIL_PWM2, 8'h20);
    wr(OFS_CEIL_PWM3, 8'h7f);
    rd(OFS_CEIL_PWM2);
    `CHK(got, 8'h20)
    demand(8'h80);
    `CHK({pwmDuty1, pwmDuty2, pwmDuty3}, 24'h40207f)
    demand(8'h10);
    `CHK({pwmDuty1, pwmDuty2, pwmDuty3}, 24'h101010)
    demand(8'h80);
    wr(OFS_SETUP, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(monitorRun, 1'b0)
    `CHK({pwmDuty1, pwmDuty2, pwmDuty3}, 24'h808080)
    rd(OFS_CEIL_PWM1);
    `CHK(got, 8'h40)
    wr(OFS_SETUP, 8'h08);
    repeat (2) @(posedge clk);
    `CHK({pwmDuty1, pwmDuty2, pwmDuty3}, 24'hffffff)
    wr(OFS_SETUP, 8'h09);
    demand(8'h10);
    `CHK(forceFullFan, 1'b1)
    `CHK({pwmDuty1, pwmDuty2, pwmDuty3}, 24'h40207f)
    wr(OFS_SETUP, 8'hf1);
    repeat (2) @(posedge clk);
    `CHK({supply5vSelect, busTimeoutSelect, spinupPulseSkip, powerCalcFlag}, 4'hf)
    rd(OFS_SETUP);
    `CHK(got, 8'hf5)
    wr(OFS_ADJ_INTERVAL, 8'h03);
    wr(OFS_SETUP, 8'hf3);
    // Locked bits stay put; the full fan and spin-up bits still follow writes
    wr(OFS_SETUP, 8'h08);
    rd(OFS_SETUP);
    `CHK(got, 8'hdf)
    `CHK({monitorRun, lockActive, forceFullFan, spinupPulseSkip}, 4'he)
    wr(OFS_CEIL_PWM1, 8'h11);
    wr(OFS_ADJ_INTERVAL, 8'h05);
    rd(OFS_CEIL_PWM1);
    `CHK(got, 8'h40)
    rd(OFS_ADJ_INTERVAL);
    `CHK(got, 8'h03)
    doReset();
    rd(OFS_SETUP);
    `CHK(got, 8'h01)
    rd(OFS_CEIL_PWM1);
    `CHK(got, 8'hff)
    // Ticks are ignored while monitoring is stopped
    wr(OFS_SETUP, 8'h00);
    ticks(20);
    `CHK(nDec, 0)
    for (int c = 0; c < 8; c++) begin
      doReset();
      wr(OFS_ADJ_INTERVAL, 8'(c));
      ticks((8 << c) - 1);
      `CHK(nDec, 0)
      ticks(1);
      `CHK(nDec, 1)
      `CHK(nInc, 0)
      ticks(8 << c);
      `CHK(nDec, 2)
      `CHK(nInc, 1)
    end
    endSim();
  end
endmodule : fmc_config_lock_bank_bench
`default_nettype wire
